// File: pkg/smo_pkg.sv
// Constants, types and helpers shared by the stack and option register block
package smo_pkg;

	// ********************************************************
	// Command codes and field layout
	// ********************************************************
	localparam logic [7:0] SMO_CMD_STACK     = 8'hEC;
	localparam logic [7:0] SMO_CMD_MISC      = 8'hED;
	localparam int         SMO_POS_PEC       = 15;
	localparam int         SMO_POS_RST_SHDN  = 14;
	localparam int         SMO_POS_RST_FLT   = 13;
	localparam int         SMO_POS_PIN_FN    = 12;
	localparam int         SMO_POS_PULLUP_N  = 3;
	localparam int         SMO_POS_DECAY     = 2;
	localparam int         SMO_POS_RES_HI    = 1;
	localparam int         SMO_POS_RES_LO    = 0;

	// ********************************************************
	// Values and reset contents
	// ********************************************************
	localparam logic [7:0]  SMO_RSVD_HI      = 8'h00;
	localparam logic [3:0]  SMO_MASTER_POS   = 4'h0;
	localparam logic [3:0]  SMO_STACK_ALONE  = 4'h0;
	localparam logic [15:0] SMO_STACK_MAX    = 16'h0003;
	localparam logic [3:0]  SMO_STACK_RST    = 4'h0;
	localparam logic [15:0] SMO_MISC_RST     = 16'h0000;
	localparam logic [7:0]  SMO_PEC_POLY     = 8'h07;
	localparam logic [7:0]  SMO_PEC_INIT     = 8'h00;
	localparam logic [3:0]  SMO_BIT_ACK      = 4'h8;
	localparam logic [3:0]  SMO_BIT_LAST     = 4'h7;
	localparam logic [3:0]  SMO_FCNT_MAX     = 4'hF;
	localparam logic [3:0]  SMO_RES_12       = 4'hC;
	localparam logic [3:0]  SMO_RES_10       = 4'hA;
	localparam logic [3:0]  SMO_RES_8        = 4'h8;
	localparam logic [3:0]  SMO_RES_6        = 4'h6;

	// ********************************************************
	// Types
	// ********************************************************
	typedef struct packed {
		logic [3:0]  nvm_stack;
		logic [3:0]  pin_stack;
		logic        stack_from_pins;
		logic [15:0] nvm_misc;
	} smo_boot_t;

	typedef struct packed {
		logic       start;
		logic       stop;
		logic       rx_valid;
		logic [7:0] rx_byte;
		logic       tx_done;
		logic       tx_nack;
	} smo_bus_ev_t;

	typedef enum logic [9:0] {
		SMO_IDLE = 10'h001,
		SMO_ADDR = 10'h002,
		SMO_CMD  = 10'h004,
		SMO_WLO  = 10'h008,
		SMO_WHI  = 10'h010,
		SMO_WPEC = 10'h020,
		SMO_RLO  = 10'h040,
		SMO_RHI  = 10'h080,
		SMO_RPEC = 10'h100,
		SMO_SKIP = 10'h200
	} smo_state_t;

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic [7:0] smo_crc8(input logic [7:0] crc,
						input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ SMO_PEC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic [3:0] smo_res_bits(input logic [1:0] code);
		logic [3:0] r;
		r = SMO_RES_12;
		unique case (code)
			2'h0: r = SMO_RES_12;
			2'h1: r = SMO_RES_10;
			2'h2: r = SMO_RES_8;
			2'h3: r = SMO_RES_6;
		endcase
		return r;
	endfunction

endpackage

// File: verilog/smo_bit_engine.sv
// Bus bit engine: pin sampling, start/stop detection, byte shifting
`timescale 1ns/1ps
`default_nettype none
module smo_bit_engine
	import smo_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	input  wire logic        ack_en,
	input  wire logic        tx_en,
	input  wire logic [7:0]  tx_byte,
	output smo_bus_ev_t      ev,
	output logic             sda_o,
	output logic             sda_oe
);

	// ********************************************************
	// Pin synchronisers
	// ********************************************************
	logic       scl_m_r, scl_s_r, scl_d_r;
	logic       sda_m_r, sda_s_r, sda_d_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic       active_r;
	logic       tx_q_r;
	logic       scl_rise, scl_fall, bus_start, bus_stop;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
		end else begin
			{scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
		end
	end

	assign scl_rise  = scl_s_r & ~scl_d_r;
	assign scl_fall  = ~scl_s_r & scl_d_r;
	assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign bus_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// ********************************************************
	// Byte engine
	// ********************************************************
	// Direction is latched at the first bit so a late tx_en change
	// from the protocol layer cannot corrupt the ack slot.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ev       <= '0;
			cnt_r    <= 4'h0;
			shift_r  <= 8'h00;
			active_r <= 1'b0;
			tx_q_r   <= 1'b0;
			sda_oe   <= 1'b0;
			sda_o    <= 1'b0;
		end else begin
			ev.start    <= 1'b0;
			ev.stop     <= 1'b0;
			ev.rx_valid <= 1'b0;
			ev.tx_done  <= 1'b0;
			sda_o       <= 1'b0;
			if (bus_start) begin
				cnt_r    <= 4'h0;
				active_r <= 1'b1;
				tx_q_r   <= 1'b0;
				sda_oe   <= 1'b0;
				ev.start <= 1'b1;
			end else if (bus_stop) begin
				active_r <= 1'b0;
				sda_oe   <= 1'b0;
				ev.stop  <= 1'b1;
			end else if (active_r && scl_rise) begin
				if (cnt_r == SMO_BIT_ACK) begin
					cnt_r <= 4'h0;
					if (tx_q_r) begin
						ev.tx_done <= 1'b1;
						ev.tx_nack <= sda_s_r;
					end
				end else begin
					shift_r <= {shift_r[6:0], sda_s_r};
					cnt_r   <= cnt_r + 4'h1;
					if (cnt_r == SMO_BIT_LAST && !tx_q_r) begin
						ev.rx_valid <= 1'b1;
						ev.rx_byte  <= {shift_r[6:0], sda_s_r};
					end
				end
			end else if (active_r && scl_fall) begin
				if (cnt_r == SMO_BIT_ACK) begin
					sda_oe <= ~tx_q_r & ack_en;
				end else if (cnt_r == 4'h0) begin
					tx_q_r <= tx_en;
					sda_oe <= tx_en & ~tx_byte[7];
				end else begin
					sda_oe <= tx_q_r & ~tx_byte[3'(SMO_BIT_LAST - cnt_r)];
				end
			end
		end
	end

endmodule
`default_nettype wire

// File: verilog/smo_regs.sv
// Stack configuration and miscellaneous option registers with bus slave
//
// Overview of operation
// (R1) Stack word upper byte reads zero, read-only
// (R2) Master position bits read-only, read zero
// (R3) Last position codes zero to three valid
// (R4) Invalid stack write rejected, data fault flagged
// (R5) Stand-alone power-up keeps back-channel pins disabled
// (R6) Later multi-phase write waits for next power-up
// (R7) Multi-phase power-up accepts live stack changes
// (R8) Host clears override, stores, cycles supply
// (R9) Override selects pin or stored stack value
// (R10) Required error byte missing gives communication fault
// (R11) Shutdown reload of boot voltage when enabled
// (R12) Fault retry restart reload when enabled
// (R13) Pin function: power good or reset
// (R14) Reset mode pull-up set by bit three
// (R15) Clean cycle decrements or clears fault counter
// (R16) Resolution code selects twelve to six bits
// (R17) Host writes zero to reserved option bits
// (R18) Word access, on-the-fly update, store back-up
// (R19) Reads return last accepted; rejects change nothing
`timescale 1ns/1ps
`default_nettype none
module smo_regs
	import smo_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic [6:0]  dev_addr,
	input  wire smo_boot_t   boot,
	input  wire logic        powerup_load,
	input  wire logic        restore_load,
	input  wire logic        conversion_enabled,
	input  wire logic        shutdown_ctrl,
	input  wire logic        fault_restart,
	input  wire logic        retry_after_fault,
	input  wire logic        power_good_in,
	input  wire logic        fault_event,
	input  wire logic        clean_cycle,
	output logic [3:0]       last_stack_position,
	output logic [15:0]      miscellaneous_options,
	output logic             backchannel_enable,
	output logic [3:0]       active_last_position,
	output logic             reload_boot_voltage,
	output logic             good_or_reset_pin_o,
	output logic             good_or_reset_pin_oe,
	output logic             good_or_reset_pullup_en,
	output logic             good_or_reset_is_reset,
	output logic [3:0]       fault_count,
	output logic [3:0]       telemetry_resolution,
	output logic             status_data_fault,
	output logic             status_comm_fault,
	output logic             nvm_misc_write
);

	// ********************************************************
	// Declarations
	// ********************************************************
	smo_bus_ev_t ev;
	smo_state_t  state_r;
	logic [7:0]  cmd_r, crc_r, lo_r, tx_byte_r;
	logic [15:0] wr_word_r, misc_r, rd_word;
	logic [3:0]  stack_r, active_r, fcnt_r, res_r;
	logic        ack_en_r, tx_en_r, rs_r, pec_seen_r, word_rx_r;
	logic        bc_en_r, reload_r, pin_oe_r, pullup_r, pin_rst_r;
	logic        data_fault_r, comm_fault_r, nvm_wr_r;
	logic        write_end, comm_bad, cmd_stack, stack_bad;
	logic [3:0]  boot_stack;

	smo_bit_engine smo_bit_engine_inst (
		.clk     (clk),
		.rst_n   (rst_n),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.ack_en  (ack_en_r),
		.tx_en   (tx_en_r),
		.tx_byte (tx_byte_r),
		.ev      (ev),
		.sda_o   (sda_o),
		.sda_oe  (sda_oe)
	);

	assign cmd_stack = (cmd_r == SMO_CMD_STACK);
	// (R1) Fixed upper byte and position
	// (R2) Master position reads zero
	assign rd_word   = cmd_stack ? {SMO_RSVD_HI, SMO_MASTER_POS, stack_r}
				 : misc_r;
	assign write_end = ev.stop && word_rx_r;
	// (R10) Missing error byte check
	assign comm_bad  = pec_seen_r ? (crc_r != SMO_PEC_INIT)
				  : misc_r[SMO_POS_PEC];
	// (R3) Valid code range
	// Writes during conversion are refused: the stack is read-only then.
	assign stack_bad = (wr_word_r > SMO_STACK_MAX) || conversion_enabled;
	// (R9) Source selected by override
	assign boot_stack = boot.stack_from_pins ? boot.pin_stack
						 : boot.nvm_stack;

	// ********************************************************
	// Transaction sequencer
	// ********************************************************
	// (R18) Word-wide write and read sequencing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r    <= SMO_IDLE;
			cmd_r      <= 8'h00;
			crc_r      <= SMO_PEC_INIT;
			lo_r       <= 8'h00;
			wr_word_r  <= 16'h0000;
			tx_byte_r  <= 8'hFF;
			ack_en_r   <= 1'b0;
			tx_en_r    <= 1'b0;
			rs_r       <= 1'b0;
			pec_seen_r <= 1'b0;
			word_rx_r  <= 1'b0;
		end else if (ev.start) begin
			rs_r    <= (state_r == SMO_WLO);
			ack_en_r <= 1'b0;
			tx_en_r <= 1'b0;
			state_r <= SMO_ADDR;
			if (state_r != SMO_WLO) begin
				crc_r      <= SMO_PEC_INIT;
				pec_seen_r <= 1'b0;
				word_rx_r  <= 1'b0;
			end
		end else if (ev.stop) begin
			state_r  <= SMO_IDLE;
			ack_en_r <= 1'b0;
			tx_en_r  <= 1'b0;
			word_rx_r <= 1'b0;
			pec_seen_r <= 1'b0;
		end else if (ev.rx_valid) begin
			crc_r    <= smo_crc8(crc_r, ev.rx_byte);
			ack_en_r <= 1'b1;
			unique case (state_r)
				SMO_ADDR: begin
					if (ev.rx_byte[7:1] != dev_addr) begin
						ack_en_r <= 1'b0;
						state_r  <= SMO_SKIP;
					end else if (!ev.rx_byte[0]) begin
						state_r <= SMO_CMD;
					end else if (rs_r) begin
						tx_en_r   <= 1'b1;
						tx_byte_r <= rd_word[7:0];
						state_r   <= SMO_RLO;
					end else begin
						ack_en_r <= 1'b0;
						state_r  <= SMO_SKIP;
					end
				end
				SMO_CMD: begin
					cmd_r <= ev.rx_byte;
					if (ev.rx_byte == SMO_CMD_STACK ||
					    ev.rx_byte == SMO_CMD_MISC) begin
						state_r <= SMO_WLO;
					end else begin
						ack_en_r <= 1'b0;
						state_r  <= SMO_SKIP;
					end
				end
				SMO_WLO: begin
					lo_r    <= ev.rx_byte;
					state_r <= SMO_WHI;
				end
				SMO_WHI: begin
					wr_word_r <= {ev.rx_byte, lo_r};
					word_rx_r <= 1'b1;
					state_r   <= SMO_WPEC;
				end
				SMO_WPEC: begin
					pec_seen_r <= 1'b1;
					state_r    <= SMO_SKIP;
				end
				default: begin
					ack_en_r <= 1'b0;
					state_r  <= SMO_SKIP;
				end
			endcase
		end else if (ev.tx_done) begin
			crc_r <= smo_crc8(crc_r, tx_byte_r);
			if (ev.tx_nack || state_r == SMO_RPEC) begin
				tx_en_r <= 1'b0;
				state_r <= SMO_SKIP;
			end else if (state_r == SMO_RLO) begin
				tx_byte_r <= rd_word[15:8];
				state_r   <= SMO_RHI;
			end else begin
				tx_byte_r <= smo_crc8(crc_r, tx_byte_r);
				state_r   <= SMO_RPEC;
			end
		end
	end

	// ********************************************************
	// Register storage and reload
	// ********************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stack_r      <= SMO_STACK_RST;
			misc_r       <= SMO_MISC_RST;
			data_fault_r <= 1'b0;
			comm_fault_r <= 1'b0;
			nvm_wr_r     <= 1'b0;
		end else begin
			data_fault_r <= 1'b0;
			comm_fault_r <= 1'b0;
			nvm_wr_r     <= 1'b0;
			if (powerup_load || restore_load) begin
				// (R9) Reload stack source
				stack_r <= boot_stack;
				misc_r  <= boot.nvm_misc;
			end else if (write_end) begin
				// (R19) Rejected writes leave contents
				if (comm_bad) begin
					comm_fault_r <= 1'b1;
				end else if (cmd_stack) begin
					// (R4) Reject unsupported data
					if (stack_bad) begin
						data_fault_r <= 1'b1;
					end else begin
						stack_r <= wr_word_r[3:0];
					end
				end else begin
					// (R18) On-the-fly update, back-up
					misc_r   <= wr_word_r;
					nvm_wr_r <= 1'b1;
				end
			end
		end
	end

	// ********************************************************
	// Back-channel enable
	// ********************************************************
	// Decided only at power-up; a restore or a write cannot turn the
	// pins on, since the stack partners were not wired up at boot.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bc_en_r  <= 1'b0;
			active_r <= SMO_STACK_ALONE;
		end else begin
			// (R5) Stand-alone boot disables pins
			// (R6) Enable waits for power-up
			if (powerup_load) begin
				bc_en_r <= (boot_stack != SMO_STACK_ALONE);
			end
			// (R7) Live changes when enabled
			active_r <= bc_en_r ? stack_r : SMO_STACK_ALONE;
		end
	end

	// ********************************************************
	// Option effects
	// ********************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reload_r  <= 1'b0;
			pin_oe_r  <= 1'b1;
			pullup_r  <= 1'b0;
			pin_rst_r <= 1'b0;
			res_r     <= SMO_RES_12;
		end else begin
			// (R11) Shutdown reload
			// (R12) Fault restart reload
			reload_r  <= (shutdown_ctrl && misc_r[SMO_POS_RST_SHDN]) ||
				     (fault_restart && retry_after_fault &&
				      misc_r[SMO_POS_RST_FLT]);
			// (R13) Open-drain low while power not good
			pin_oe_r  <= ~power_good_in;
			pin_rst_r <= misc_r[SMO_POS_PIN_FN];
			// (R14) Pull-up only in reset mode
			pullup_r  <= misc_r[SMO_POS_PIN_FN] &
				     ~misc_r[SMO_POS_PULLUP_N];
			// (R16) Resolution decode
			res_r     <= smo_res_bits(misc_r[SMO_POS_RES_HI:SMO_POS_RES_LO]);
		end
	end

	// (R15) Fault counter decay
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fcnt_r <= 4'h0;
		end else if (fault_event) begin
			if (fcnt_r != SMO_FCNT_MAX) begin
				fcnt_r <= fcnt_r + 4'h1;
			end
		end else if (clean_cycle) begin
			if (misc_r[SMO_POS_DECAY]) begin
				fcnt_r <= 4'h0;
			end else if (fcnt_r != 4'h0) begin
				fcnt_r <= fcnt_r - 4'h1;
			end
		end
	end

	assign last_stack_position     = stack_r;
	assign miscellaneous_options   = misc_r;
	assign backchannel_enable      = bc_en_r;
	assign active_last_position    = active_r;
	assign reload_boot_voltage     = reload_r;
	assign good_or_reset_pin_o     = 1'b0;
	assign good_or_reset_pin_oe    = pin_oe_r;
	assign good_or_reset_pullup_en = pullup_r;
	assign good_or_reset_is_reset  = pin_rst_r;
	assign fault_count             = fcnt_r;
	assign telemetry_resolution    = res_r;
	assign status_data_fault       = data_fault_r;
	assign status_comm_fault       = comm_fault_r;
	assign nvm_misc_write          = nvm_wr_r;

	// ********************************************************
	// Checks
	// ********************************************************
	stack_hi_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // (R1)
		(state_r == SMO_RHI && cmd_stack) |-> tx_byte_r == 8'h00)
		else $error("stack upper byte not zero");
	master_pos_a: assert property (@(posedge clk) disable iff (!rst_n) // (R2)
		(state_r == SMO_RLO && cmd_stack) |-> tx_byte_r[7:4] == 4'h0)
		else $error("master position not zero");
	stack_range_a: assert property (@(posedge clk) disable iff (!rst_n) // (R3)
		!$past(powerup_load) && !$past(restore_load) |-> stack_r <= 4'h3)
		else $error("stack code out of range");
	bad_stack_a: assert property (@(posedge clk) disable iff (!rst_n) // (R4)
		(write_end && !comm_bad && cmd_stack && stack_bad &&
		 !powerup_load && !restore_load)
		|=> status_data_fault && $stable(stack_r))
		else $error("invalid stack write not rejected");
	alone_boot_a: assert property (@(posedge clk) disable iff (!rst_n) // (R5)
		(powerup_load && boot_stack == 4'h0) |=> !bc_en_r [*3])
		else $error("back-channel enabled after stand-alone boot");
	late_enable_a: assert property (@(posedge clk) disable iff (!rst_n) // (R6)
		(!bc_en_r && !powerup_load) |=> !bc_en_r)
		else $error("back-channel enabled without power-up");
	live_stack_a: assert property (@(posedge clk) disable iff (!rst_n) // (R7)
		$past(bc_en_r) |-> active_r == $past(stack_r))
		else $error("live stack change not followed");
	pec_req_a: assert property (@(posedge clk) disable iff (!rst_n) // (R10)
		(write_end && !pec_seen_r && misc_r[15] && !powerup_load &&
		 !restore_load) |=> status_comm_fault && $stable(misc_r))
		else $error("missing error byte accepted");
	boot_reload_a: assert property (@(posedge clk) disable iff (!rst_n) // (R11)
		(shutdown_ctrl && misc_r[14]) |=> reload_boot_voltage)
		else $error("no boot reload on shutdown");
	pullup_a: assert property (@(posedge clk) disable iff (!rst_n) // (R14)
		##1 good_or_reset_pullup_en == ($past(misc_r[12]) &&
						!$past(misc_r[3])))
		else $error("pull-up control wrong");
	decay_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // (R15)
		(clean_cycle && !fault_event && misc_r[2]) |=> fault_count == 4'h0)
		else $error("fault counter not cleared");
	misc_store_a: assert property (@(posedge clk) disable iff (!rst_n) // (R18)
		(write_end && !comm_bad && !cmd_stack && !powerup_load &&
		 !restore_load) |=> nvm_misc_write && misc_r == $past(wr_word_r))
		else $error("option write not applied");

endmodule
`default_nettype wire

// File: sim/smo_host_model.sv
// Bus host model issuing word reads and writes with optional error byte
`timescale 1ns/1ps
`default_nettype none
module smo_host_model (
	input  wire logic       clk,
	input  wire logic       sda_in,
	input  wire logic [6:0] addr,
	output logic            scl,
	output logic            sda_oe
);
	// Clock stands high between frames, data released
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] c,
					    input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++) begin
			x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
		end
		return x;
	endfunction

	// ****
	// Bit, start and stop timing
	// ****
	// Data moves only while clock is low; each phase 10 cycles, 40 per bit
	task automatic bit_io(input logic b, output logic r);
		sda_oe = ~b;
		w(10);
		scl = 1'b1;
		w(10);
		r = sda_in;
		w(10);
		scl = 1'b0;
		w(10);
	endtask

	task automatic start();
		sda_oe = 1'b0;
		w(10);
		scl = 1'b1;
		w(10);
		sda_oe = 1'b1;
		w(10);
		scl = 1'b0;
		w(10);
	endtask

	task automatic stop();
		sda_oe = 1'b1;
		w(10);
		scl = 1'b1;
		w(10);
		sda_oe = 1'b0;
		w(10);
	endtask

	task automatic tx(input logic [7:0] d, inout logic [7:0] c,
			  inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ok &= ~r;
		c = crc8(c, d);
	endtask

	task automatic rx(input logic ack, output logic [7:0] d,
			  inout logic [7:0] c);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
		c = crc8(c, d);
	endtask

	// ****
	// Word transfers
	// ****
	// Word access, low byte first
	task automatic write_word(input logic [7:0] cmd,
				  input logic [15:0] v, input logic pec,
				  output logic ok);
		logic [7:0] c;
		c = 8'h00;
		ok = 1'b1;
		start();
		tx({addr, 1'b0}, c, ok);
		tx(cmd, c, ok);
		tx(v[7:0], c, ok);
		tx(v[15:8], c, ok);
		if (pec) tx(c, c, ok);
		stop();
	endtask

	// Word read, optional error byte checked
	task automatic read_word(input logic [7:0] cmd, input logic pec,
				 output logic [15:0] v, output logic ok);
		logic [7:0] c;
		logic [7:0] p;
		c = 8'h00;
		ok = 1'b1;
		start();
		tx({addr, 1'b0}, c, ok);
		tx(cmd, c, ok);
		start();
		tx({addr, 1'b1}, c, ok);
		rx(1'b1, v[7:0], c);
		rx(pec, v[15:8], c);
		if (pec) begin
			rx(1'b0, p, c);
			ok &= (c == 8'h00);
		end
		stop();
	endtask
endmodule
`default_nettype wire

// File: sim/tb_smo_regs.sv
// Self-checking bench for the stack and option register block
`timescale 1ns/1ps
`default_nettype none
module tb_smo_regs
	import smo_pkg::*;
;
	localparam logic [3:0] RES_EXP [4] = '{4'hC, 4'hA, 4'h8, 4'h6};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        scl, h_oe, sda_o, sda_oe, ok, pin_o;
	logic [6:0]  dev_addr = 7'h2A;
	smo_boot_t   boot = '0;
	logic        powerup_load = 0, restore_load = 0, shutdown_ctrl = 0;
	logic        fault_restart = 0, fault_event = 0, clean_cycle = 0;
	logic        conversion_enabled = 0, retry_after_fault = 0;
	logic        power_good_in = 0;
	logic [3:0]  last_stack_position, active_last_position;
	logic [3:0]  fault_count, telemetry_resolution;
	logic [15:0] miscellaneous_options, v, rv;
	logic        backchannel_enable, reload_boot_voltage;
	logic        good_or_reset_pin_oe, good_or_reset_pullup_en;
	logic        good_or_reset_is_reset, status_data_fault;
	logic        status_comm_fault, nvm_misc_write;
	logic [1:0]  k;
	int          num_errors = 0, num_checks = 0;
	int          n_df = 0, n_cf = 0, n_rl = 0, n_nv = 0;
	wire         sda = ~(h_oe | sda_oe);

	always #2 clk = ~clk;

	smo_regs smo_regs_inst (.clk, .rst_n, .scl_i(scl), .sda_i(sda), .sda_o,
		.sda_oe, .dev_addr, .boot, .powerup_load, .restore_load,
		.conversion_enabled, .shutdown_ctrl, .fault_restart,
		.retry_after_fault, .power_good_in, .fault_event, .clean_cycle,
		.last_stack_position, .miscellaneous_options,
		.backchannel_enable, .active_last_position, .reload_boot_voltage,
		.good_or_reset_pin_o(pin_o), .good_or_reset_pin_oe,
		.good_or_reset_pullup_en, .good_or_reset_is_reset, .fault_count,
		.telemetry_resolution, .status_data_fault, .status_comm_fault,
		.nvm_misc_write);

	smo_host_model host (.clk, .sda_in(sda), .addr(dev_addr), .scl,
		.sda_oe(h_oe));

	// Pulses are one cycle wide, so they are counted as they pass
	always @(posedge clk) begin
		if (status_data_fault === 1'b1) n_df++;
		if (status_comm_fault === 1'b1) n_cf++;
		if (reload_boot_voltage === 1'b1) n_rl++;
		if (nvm_misc_write === 1'b1) n_nv++;
	end

	// ****
	// Shared tasks
	// ****
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(2);
	endtask

	task automatic check(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				 s, e);
		end
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d,
			  input logic pec);
		host.write_word(c, d, pec, ok);
		step(6);
	endtask

	task automatic test_end(input string name);
		$display("Test %s finished", name);
	endtask

	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		step(80000);
		num_errors++;
		give_verdict();
	end

	// ****
	// Tests
	// ****
	initial begin
		step(20);
		rst_n = 1'b1;
		step(4);
		check(telemetry_resolution, 4'hC);
		check(good_or_reset_pin_oe, 1'b1);
		check(pin_o, 1'b0);
		boot.pin_stack = 4'h3;
		pulse(powerup_load);
		check(last_stack_position, 4'h0);
		check(backchannel_enable, 1'b0);
		wr(SMO_CMD_STACK, 16'h0002, 1'b0);
		check(ok, 1'b1);
		check(last_stack_position, 4'h2);
		check(backchannel_enable, 1'b0);
		check(active_last_position, 4'h0);
		host.read_word(SMO_CMD_STACK, 1'b0, rv, ok);
		check(rv, 16'h0002);
		wr(SMO_CMD_STACK, 16'h0005, 1'b0);
		wr(SMO_CMD_STACK, 16'h00F1, 1'b0);
		wr(SMO_CMD_STACK, 16'h0102, 1'b0);
		conversion_enabled = 1'b1;
		wr(SMO_CMD_STACK, 16'h0001, 1'b0);
		conversion_enabled = 1'b0;
		check(n_df, 4);
		check(last_stack_position, 4'h2);
		test_end("standalone");
		boot.nvm_stack = 4'h2;
		pulse(powerup_load);
		check(backchannel_enable, 1'b1);
		check(active_last_position, 4'h2);
		for (int i = 3; i >= 0; i--) begin
			wr(SMO_CMD_STACK, 16'(i), 1'b0);
			check(last_stack_position, 4'(i));
			check(active_last_position, 4'(i));
		end
		check(backchannel_enable, 1'b1);
		boot.stack_from_pins = 1'b1;
		pulse(restore_load);
		check(last_stack_position, 4'h3);
		host.read_word(8'hEE, 1'b0, rv, ok);
		check(ok, 1'b0);
		test_end("stack");
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			v = {3'h0, k[0], 8'h00, k[1], k[0], k};
			wr(SMO_CMD_MISC, v, 1'b0);
			check(miscellaneous_options, v);
			check(telemetry_resolution, RES_EXP[i]);
			check(good_or_reset_is_reset, k[0]);
			check(good_or_reset_pullup_en, k[0] & ~k[1]);
			host.read_word(SMO_CMD_MISC, k[1], rv, ok);
			check(rv, v);
			check(ok, 1'b1);
		end
		check(n_nv, 4);
		power_good_in = 1'b1;
		step(2);
		check(good_or_reset_pin_oe, 1'b0);
		power_good_in = 1'b0;
		step(2);
		check(good_or_reset_pin_oe, 1'b1);
		test_end("options");
		wr(SMO_CMD_MISC, 16'h0000, 1'b0);
		fault_event = 1'b1;
		step(3);
		fault_event = 1'b0;
		step(1);
		check(fault_count, 4'h3);
		pulse(clean_cycle);
		check(fault_count, 4'h2);
		wr(SMO_CMD_MISC, 16'h0004, 1'b0);
		pulse(clean_cycle);
		check(fault_count, 4'h0);
		wr(SMO_CMD_MISC, 16'h4000, 1'b0);
		pulse(shutdown_ctrl);
		retry_after_fault = 1'b1;
		pulse(fault_restart);
		check(n_rl, 1);
		wr(SMO_CMD_MISC, 16'h2000, 1'b0);
		pulse(shutdown_ctrl);
		check(n_rl, 1);
		pulse(fault_restart);
		check(n_rl, 2);
		retry_after_fault = 1'b0;
		pulse(fault_restart);
		check(n_rl, 2);
		test_end("reload");
		wr(SMO_CMD_MISC, 16'h8000, 1'b0);
		check(miscellaneous_options, 16'h8000);
		wr(SMO_CMD_MISC, 16'h8001, 1'b0);
		check(n_cf, 1);
		check(miscellaneous_options, 16'h8000);
		wr(SMO_CMD_MISC, 16'h8002, 1'b1);
		check(miscellaneous_options, 16'h8002);
		check(n_cf, 1);
		test_end("error byte");
		give_verdict();
	end
endmodule
`default_nettype wire
